// ===== shared/map_aux_pkg.sv
// Shared constants and types for the plan-frame auxiliary sub-field codec
package map_aux_pkg;
   // ****************************************
   // Sub-field codes and octet positions
   // ****************************************
   localparam logic [6:0] TYPE_INTERFERENCE = 7'h0c;
   localparam logic [6:0] TYPE_POWER_SAVE = 7'h0f;
   localparam int FLAG_BIT = 7;
   localparam int IM_FIXED_LEN = 28;
   localparam int PS_FIXED_LEN = 8;
   localparam logic [7:0] WAKE_ALL = 8'hff;
   localparam int LIST_DEPTH = 256;
   localparam int FIFO_DEPTH = 16;
   localparam logic [7:0] PRESENCE_NORMAL = 8'h00;
   localparam logic [7:0] PRESENCE_ACCEPT = 8'h01;
   localparam logic [7:0] PRESENCE_REJECT_CLUSTER = 8'h02;
   localparam logic [7:0] PRESENCE_REJECT_BUSY = 8'h03;
   localparam logic [7:0] FIELD_OCTET = 8'h02;
   localparam logic [7:0] PS_COUNT_OCTET = 8'h09;
   localparam logic [7:0] PS_LIST_OCTET = 8'h0a;
   localparam logic [7:0] PRESENCE_OCTET = 8'h1c;
   localparam logic [7:0] IM_COUNT_OCTET = 8'h1d;
   localparam logic [7:0] IM_LIST_OCTET = 8'h1e;

   // ****************************************
   // Field record types
   // ****************************************
   typedef struct packed {
      logic changedFlag;
      logic [47:0] clusterIdentifier;
      logic [47:0] masterRegistrationIdentifier;
      logic [15:0] clusterCycleCounter;
      logic [23:0] syncReferenceDomainIdentifier;
      logic [23:0] ownDomainIdentifier;
      logic [47:0] senderMacAddress;
      logic [7:0] presenceHandshakeCode;
      logic [7:0] authorizedSenderCount;
   } interference_fields_t;

   typedef struct packed {
      logic [7:0] sleepCycleStartDelay;
      logic [15:0] defaultInactiveDuration;
      logic [15:0] defaultActiveDuration;
      logic [15:0] defaultIntracycleActivityMap;
      logic [7:0] wakeRequestCount;
   } power_fields_t;
endpackage

// ===== shared/map_aux_link_if.sv
// Octet stream link between the framer and the parser
`timescale 1ns/10ps
interface map_aux_link_if;
   logic [7:0] data;
   logic valid;
   logic last;
   logic ready;
   modport framer (output data, output valid, output last, input ready);
   modport parser (input data, input valid, input last, output ready);
endinterface

// ===== rtl/map_aux_fifo.sv
// Parameterised valid/ready FIFO
`timescale 1ns/10ps
module map_aux_fifo #(
   parameter int WIDTH = 9,
   parameter int DEPTH = map_aux_pkg::FIFO_DEPTH
) (
   // Clock and reset
   input wire logic clock,
   input wire logic rst_b,
   // Fill side
   input wire logic [WIDTH-1:0] inData,
   input wire logic inValid,
   output logic inReady,
   // Drain side
   output logic [WIDTH-1:0] outData,
   output logic outValid,
   input wire logic outReady
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] store [DEPTH];
   logic [AW-1:0] wrPtr;
   logic [AW-1:0] rdPtr;
   logic [AW:0] count;
   wire push = inValid && inReady;
   wire pop = outValid && outReady;
   assign inReady = count != (AW+1)'(DEPTH);
   assign outValid = count != '0;
   assign outData = store[rdPtr];
   always_ff @(posedge clock) begin
      if (push) begin
         store[wrPtr] <= inData;
      end
   end
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         wrPtr <= '0;
         rdPtr <= '0;
         count <= '0;
      end else begin
         if (push) begin
            wrPtr <= (wrPtr == AW'(DEPTH-1)) ? '0 : wrPtr + 1'b1;
         end
         if (pop) begin
            rdPtr <= (rdPtr == AW'(DEPTH-1)) ? '0 : rdPtr + 1'b1;
         end
         count <= count + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
endmodule

// ===== rtl/map_aux_framer.sv
// Domain master end: builds either sub-field, one per request, into an octet stream
// Functional notes
// R1 - Interference type 0c, variable length
// R2 - Interference changed flag either value
// R3 - Length octet is full, content dependent
// R4 - Cluster and master identifiers, octets 2-13
// R5 - Cycle counter in octets 14-15
// R6 - Reference and own domain identifiers
// R7 - Sender MAC address octets 22-27
// R8 - Presence handshake code octet 28
// R9 - Authorized count; zero suppresses presence
// R10 - Authorized entries follow the count
// R11 - Power type 0f, flag one
// R12 - Sleep start delay in octet 2
// R13 - Inactive duration octets 3-4
// R14 - Active duration octets 5-6
// R15 - Activity map octets 7-8
// R16 - Wake count; 255 wakes all
// R17 - Wake entries from octet 10
// R18 - Reserved bits zero out, ignored in
// R19 - Multi-octet fields least significant first
`timescale 1ns/10ps
module map_aux_framer (
   // Clock and reset
   input wire logic clock,
   input wire logic rst_b,
   // Build request
   input wire logic sendInterference,
   input wire logic sendPower,
   input wire map_aux_pkg::interference_fields_t imFields,
   input wire map_aux_pkg::power_fields_t psFields,
   output logic busy,
   // List loading
   input wire logic listWrite,
   input wire logic [7:0] listAddr,
   input wire logic [7:0] listData,
   // Link
   map_aux_link_if.framer link
);
   // ****************************************
   // State and holding registers
   // ****************************************
   typedef enum {IDLE, EMIT} state_t;
   state_t state;
   logic isPower;
   logic [7:0] index;
   logic [7:0] listLen;
   logic [8:0] total;
   logic [7:0] list [map_aux_pkg::LIST_DEPTH];
   logic inReady;
   map_aux_pkg::interference_fields_t imHold;
   map_aux_pkg::power_fields_t psHold;
   logic [8:0] outWord;
   logic outValid;
   logic [8:0] linkWord;
   logic linkValid;

   // ****************************************
   // Octet selection
   // ****************************************
   wire [207:0] imFlat = {imHold.senderMacAddress,
      imHold.ownDomainIdentifier, imHold.syncReferenceDomainIdentifier,
      imHold.clusterCycleCounter, imHold.masterRegistrationIdentifier,
      imHold.clusterIdentifier}; // R19
   wire [63:0] psFlat = {8'h00, psHold.defaultIntracycleActivityMap, // R18
      psHold.defaultActiveDuration, psHold.defaultInactiveDuration,
      psHold.sleepCycleStartDelay}; // R19
   wire [7:0] fixedLen = isPower ? 8'(map_aux_pkg::PS_FIXED_LEN)
      : 8'(map_aux_pkg::IM_FIXED_LEN);
   wire [7:0] lengthOctet = 8'(fixedLen + listLen); // R3
   wire [7:0] fieldOffset = index - map_aux_pkg::FIELD_OCTET;
   wire [7:0] imOctet = imFlat[8*fieldOffset +: 8]; // R4 R5 R6 R7
   wire [7:0] psOctet = psFlat[8*fieldOffset +: 8]; // R12 R13 R14 R15
   wire [7:0] headOctet = isPower
      ? {1'b1, map_aux_pkg::TYPE_POWER_SAVE} // R11
      : {imHold.changedFlag, map_aux_pkg::TYPE_INTERFERENCE}; // R1 R2
   wire [7:0] listBase = isPower ? map_aux_pkg::PS_LIST_OCTET
      : map_aux_pkg::IM_LIST_OCTET;
   wire [7:0] countPos = isPower ? map_aux_pkg::PS_COUNT_OCTET
      : map_aux_pkg::IM_COUNT_OCTET;
   wire [7:0] countOctet = isPower ? psHold.wakeRequestCount // R16
      : imHold.authorizedSenderCount; // R9
   wire atHead = index == 8'h00;
   wire atLength = index == 8'h01;
   wire atList = index >= listBase;
   wire atCount = index == countPos;
   wire atPresence = !isPower && index == map_aux_pkg::PRESENCE_OCTET;
   logic [7:0] octet;
   always_comb begin
      if (atHead) begin
         octet = headOctet;
      end else if (atLength) begin
         octet = lengthOctet;
      end else if (atList) begin
         octet = list[8'(index - listBase)]; // R10 R17
      end else if (atCount) begin
         octet = countOctet;
      end else if (atPresence) begin
         octet = imHold.presenceHandshakeCode; // R8
      end else if (isPower) begin
         octet = psOctet;
      end else begin
         octet = imOctet;
      end
   end
   wire lastOctet = {1'b0, index} == total - 9'h001;
   wire push = state == EMIT && inReady;

   // ****************************************
   // Request decoding
   // ****************************************
   wire startAny = sendInterference || sendPower;
   wire frameStart = state == IDLE && startAny;
   wire frameEnd = push && lastOctet;
   wire wakeEveryone = psFields.wakeRequestCount == map_aux_pkg::WAKE_ALL;
   wire [7:0] wakeListLen = wakeEveryone ? 8'h00
      : psFields.wakeRequestCount; // R16 R17
   wire [7:0] nextListLen = sendInterference
      ? imFields.authorizedSenderCount : wakeListLen; // R9 R10
   wire [8:0] nextFixedLen = sendInterference
      ? 9'(map_aux_pkg::IM_FIXED_LEN + 2)
      : 9'(map_aux_pkg::PS_FIXED_LEN + 2);
   wire [8:0] nextTotal = nextFixedLen + {1'b0, nextListLen};

   // ****************************************
   // Sequencing
   // ****************************************
   always_ff @(posedge clock) begin
      if (listWrite && state == IDLE) begin
         list[listAddr] <= listData;
      end
   end
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         state <= IDLE;
         busy <= 1'b0;
      end else begin
         case (state)
            IDLE: begin
               if (frameStart) begin
                  state <= EMIT;
                  busy <= 1'b1;
               end
            end
            EMIT: begin
               if (frameEnd) begin
                  state <= IDLE;
                  busy <= 1'b0;
               end
            end
            default: begin
               state <= IDLE;
               busy <= 1'b0;
            end
         endcase
      end
   end
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         index <= 8'h00;
      end else if (frameStart) begin
         index <= 8'h00;
      end else if (push) begin
         index <= index + 8'h01;
      end
   end
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         isPower <= 1'b0;
         listLen <= 8'h00;
         total <= 9'h000;
         imHold <= '0;
         psHold <= '0;
      end else if (frameStart) begin
         isPower <= !sendInterference;
         listLen <= nextListLen;
         total <= nextTotal;
         imHold <= imFields;
         psHold <= psFields;
      end
   end

   // ****************************************
   // Output buffering
   // ****************************************
   wire emitting = state == EMIT;
   wire drainReady = !linkValid || link.ready;
   map_aux_fifo #(.WIDTH(9), .DEPTH(map_aux_pkg::FIFO_DEPTH))
      map_aux_fifo_inst (
      .clock(clock),
      .rst_b(rst_b),
      .inData({lastOctet, octet}),
      .inValid(emitting),
      .inReady(inReady),
      .outData(outWord),
      .outValid(outValid),
      .outReady(drainReady)
   );

   // ****************************************
   // Output stage
   // ****************************************
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         linkWord <= 9'h000;
         linkValid <= 1'b0;
      end else if (drainReady) begin
         linkWord <= outWord;
         linkValid <= outValid;
      end
   end
   assign link.data = linkWord[7:0];
   assign link.last = linkWord[8];
   assign link.valid = linkValid;
endmodule

// ===== rtl/map_aux_parser.sv
// Receiving node end: parses either sub-field from the octet stream
`timescale 1ns/10ps
module map_aux_parser (
   // Clock and reset
   input wire logic clock,
   input wire logic rst_b,
   // Link
   map_aux_link_if.parser link,
   // Parsed fields
   output map_aux_pkg::interference_fields_t imFields,
   output map_aux_pkg::power_fields_t psFields,
   output logic interferenceDone,
   output logic powerDone,
   output logic presenceSuppressed,
   output logic wakeAll,
   // List entries
   output logic entryValid,
   output logic [7:0] entryData,
   output logic entryIsWake
);
   typedef enum {HEAD, BODY, SKIP} state_t;
   state_t state;
   logic isPower;
   logic [7:0] index;
   logic [7:0] length;
   logic [223:0] imFlat;
   logic [63:0] psFlat;
   logic changedHold;
   assign link.ready = 1'b1;
   wire take = link.valid;
   wire [6:0] typeCode = link.data[6:0];
   wire listZone = isPower ? index >= map_aux_pkg::PS_LIST_OCTET
      : index >= map_aux_pkg::IM_LIST_OCTET;
   wire atLength = index == 8'h01;
   wire endNow = link.last || (!atLength && index == length + 8'h01); // R3
   wire [7:0] imCountNow = index == map_aux_pkg::IM_COUNT_OCTET
      ? link.data : imFlat[223:216];
   wire [7:0] psCountNow = index == map_aux_pkg::PS_COUNT_OCTET
      ? link.data : psFlat[63:56];
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         state <= HEAD;
         isPower <= 1'b0;
         index <= '0;
         length <= '0;
         imFlat <= '0;
         psFlat <= '0;
         changedHold <= 1'b0;
         imFields <= '0;
         psFields <= '0;
         interferenceDone <= 1'b0;
         powerDone <= 1'b0;
         presenceSuppressed <= 1'b0;
         wakeAll <= 1'b0;
         entryValid <= 1'b0;
         entryData <= '0;
         entryIsWake <= 1'b0;
      end else begin
         interferenceDone <= 1'b0;
         powerDone <= 1'b0;
         entryValid <= 1'b0;
         if (take) begin
            case (state)
               HEAD: begin
                  index <= 8'd1;
                  isPower <= typeCode == map_aux_pkg::TYPE_POWER_SAVE; // R11
                  changedHold <= link.data[map_aux_pkg::FLAG_BIT]; // R2
                  if (typeCode == map_aux_pkg::TYPE_INTERFERENCE
                     || typeCode == map_aux_pkg::TYPE_POWER_SAVE) begin // R1
                     state <= link.last ? HEAD : BODY;
                  end else begin
                     state <= link.last ? HEAD : SKIP;
                  end
               end
               BODY: begin
                  index <= index + 8'd1;
                  if (atLength) begin
                     length <= link.data; // R3
                  end else if (listZone) begin
                     entryValid <= 1'b1; // R10 R17
                     entryData <= link.data;
                     entryIsWake <= isPower;
                  end else if (isPower) begin
                     psFlat[8*(index-8'd2) +: 8] <= link.data; // R19
                  end else begin
                     imFlat[8*(index-8'd2) +: 8] <= link.data; // R19
                  end
                  if (endNow) begin
                     state <= HEAD;
                     if (isPower) begin
                        powerDone <= 1'b1;
                        psFields.sleepCycleStartDelay <= psFlat[7:0]; // R12
                        psFields.defaultInactiveDuration <= psFlat[23:8]; // R13
                        psFields.defaultActiveDuration <= psFlat[39:24]; // R14
                        psFields.defaultIntracycleActivityMap
                           <= psFlat[55:40]; // R15
                        psFields.wakeRequestCount <= psCountNow;
                        wakeAll <= psCountNow == map_aux_pkg::WAKE_ALL; // R16
                     end else begin
                        interferenceDone <= 1'b1;
                        imFields.changedFlag <= changedHold; // R2
                        imFields.clusterIdentifier <= imFlat[47:0]; // R4
                        imFields.masterRegistrationIdentifier
                           <= imFlat[95:48];
                        imFields.clusterCycleCounter <= imFlat[111:96]; // R5
                        imFields.syncReferenceDomainIdentifier
                           <= imFlat[135:112]; // R6
                        imFields.ownDomainIdentifier <= imFlat[159:136];
                        imFields.senderMacAddress <= imFlat[207:160]; // R7
                        imFields.presenceHandshakeCode <= imFlat[215:208]; // R8
                        imFields.authorizedSenderCount <= imCountNow;
                        presenceSuppressed <= imCountNow == 8'h00; // R9
                     end
                  end
               end
               SKIP: begin
                  if (link.last) begin
                     state <= HEAD; // R18
                  end
               end
               default: state <= HEAD;
            endcase
         end
      end
   end
endmodule

// ===== verification/map_aux_link_sva.sv
// Link checker for the sub-field octet stream
`timescale 1ns/10ps
module map_aux_link_sva (
   // Clock and reset
   input wire logic clock,
   input wire logic rst_b,
   // Link
   input wire logic [7:0] data,
   input wire logic valid,
   input wire logic last,
   input wire logic ready
);
   // ********
   // Octet position
   // ********
   logic [8:0] octetIndex;
   logic [6:0] kind;
   logic [7:0] length;
   wire take = valid && ready;
   wire isIm = kind == 7'h0c;
   wire isPs = kind == 7'h0f;
   wire [8:0] endIndex = {1'b0, length} + 9'h001;
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         octetIndex <= 9'h000;
         kind <= 7'h00;
         length <= 8'h00;
      end else if (take) begin
         octetIndex <= last ? 9'h000 : octetIndex + 9'h001;
         if (octetIndex == 9'h000) begin
            kind <= data[6:0];
         end
         if (octetIndex == 9'h001) begin
            length <= data;
         end
      end
   end
   default clocking @(posedge clock); endclocking
   default disable iff (!rst_b);
   // ********
   // Assertions
   // ********
   type_code_a: assert property (
      take && octetIndex == 9'h000 |-> data[6:0] inside {7'h0c, 7'h0f})
      else $error("bad sub-field type");
   power_flag_a: assert property (
      take && octetIndex == 9'h000 && data[6:0] == 7'h0f |-> data[7])
      else $error("power flag low");
   im_length_a: assert property (
      take && octetIndex == 9'h001 && isIm |-> data >= 8'h1c)
      else $error("short interference length");
   ps_length_a: assert property (
      take && octetIndex == 9'h001 && isPs |-> data >= 8'h08)
      else $error("short power length");
   presence_code_a: assert property (
      take && octetIndex == 9'h01c && isIm |-> data <= 8'h03)
      else $error("bad presence code");
   im_count_a: assert property (
      take && octetIndex == 9'h01d && isIm |-> data == length - 8'h1c)
      else $error("authorized count off");
   ps_count_a: assert property (
      take && octetIndex == 9'h009 && isPs |->
      (data == 8'hff ? length == 8'h08 : data == length - 8'h08))
      else $error("wake count off");
   frame_end_a: assert property (
      take |-> last == (octetIndex > 9'h001 && octetIndex == endIndex))
      else $error("last misplaced");
   im_frame_c: cover property (take && last && isIm);
   ps_frame_c: cover property (take && last && isPs);
   wake_all_c: cover property (
      take && octetIndex == 9'h009 && isPs && data == 8'hff);
   no_senders_c: cover property (
      take && octetIndex == 9'h01d && isIm && data == 8'h00);
endmodule

// ===== verification/map_aux_subfield_codec_tb.sv
// Bench for the framer and parser pair
`timescale 1ns/10ps
module map_aux_subfield_codec_tb;
   // ********
   // Signals
   // ********
   logic clock;
   logic rst_b;
   logic sendInterference;
   logic sendPower;
   logic busy;
   logic listWrite;
   logic [7:0] listAddr;
   logic [7:0] listData;
   logic interferenceDone;
   logic powerDone;
   logic presenceSuppressed;
   logic wakeAll;
   logic entryValid;
   logic [7:0] entryData;
   logic entryIsWake;
   map_aux_pkg::interference_fields_t imIn;
   map_aux_pkg::interference_fields_t imOut;
   map_aux_pkg::power_fields_t psIn;
   map_aux_pkg::power_fields_t psOut;
   map_aux_pkg::interference_fields_t imQ[$];
   map_aux_pkg::power_fields_t psQ[$];
   logic [8:0] streamQ[$];
   logic [8:0] entryQ[$];
   logic [255:0] noise;
   int n_mismatch;
   int samples_checked;
   map_aux_link_if link();
   map_aux_framer map_aux_framer_inst (.clock(clock), .rst_b(rst_b),
      .sendInterference(sendInterference), .sendPower(sendPower),
      .imFields(imIn), .psFields(psIn), .busy(busy),
      .listWrite(listWrite), .listAddr(listAddr), .listData(listData),
      .link(link));
   map_aux_parser map_aux_parser_inst (.clock(clock), .rst_b(rst_b),
      .link(link), .imFields(imOut), .psFields(psOut),
      .interferenceDone(interferenceDone), .powerDone(powerDone),
      .presenceSuppressed(presenceSuppressed), .wakeAll(wakeAll),
      .entryValid(entryValid), .entryData(entryData),
      .entryIsWake(entryIsWake));
   map_aux_link_sva map_aux_link_sva_inst (.clock(clock), .rst_b(rst_b),
      .data(link.data), .valid(link.valid), .last(link.last),
      .ready(link.ready));
   initial begin
      clock = 1'b0;
      forever #4 clock = ~clock;
   end
   // ********
   // Model and checks
   // ********
   task automatic finish_test();
      $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
      if (n_mismatch == 0 && samples_checked > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   task automatic check(input logic [255:0] seen, input logic [255:0] want);
      samples_checked++;
      if (seen !== want) begin
         n_mismatch++;
         $display("mismatch at %0t seen %h expected %h", $time, seen, want);
      end
   endtask
   task automatic push(input logic [47:0] value, input int count);
      for (int k = 0; k < count; k++) begin
         streamQ.push_back({1'b0, value[8*k +: 8]});
      end
   endtask
   always @(posedge clock) begin
      if (link.valid === 1'b1 && link.ready === 1'b1) begin
         check({link.last, link.data}, streamQ.pop_front());
      end
      if (entryValid === 1'b1) begin
         check({entryIsWake, entryData}, entryQ.pop_front());
      end
      if (interferenceDone === 1'b1) begin
         check(imOut, imQ[0]);
         check(presenceSuppressed, imQ[0][7:0] == 8'h00);
         imQ.delete(0);
      end
      if (powerDone === 1'b1) begin
         check(psOut, psQ[0]);
         check(wakeAll, psQ[0][7:0] == 8'hff);
         psQ.delete(0);
      end
   end
   task automatic send_frame(input bit power, input int count, input int code);
      int n;
      int guard;
      n = (count == 255) ? 0 : count;
      for (int k = 0; k < 8; k++) begin
         noise = {noise[223:0], $urandom};
      end
      for (int k = 0; k < n; k++) begin
         listWrite = 1'b1;
         listAddr = k[7:0];
         listData = noise[8*k +: 8];
         @(posedge clock);
         #1;
      end
      listWrite = 1'b0;
      imIn = noise[224:0];
      psIn = noise[63:0];
      imIn.authorizedSenderCount = count[7:0];
      imIn.presenceHandshakeCode = code[7:0];
      psIn.wakeRequestCount = count[7:0];
      if (power) begin
         push(48'h8f, 1);
         push(48'(n + 8), 1);
         push(psIn.sleepCycleStartDelay, 1);
         push(psIn.defaultInactiveDuration, 2);
         push(psIn.defaultActiveDuration, 2);
         push(psIn.defaultIntracycleActivityMap, 2);
         push(psIn.wakeRequestCount, 1);
         psQ.push_back(psIn);
      end else begin
         push({imIn.changedFlag, 7'h0c}, 1);
         push(48'(n + 28), 1);
         push(imIn.clusterIdentifier, 6);
         push(imIn.masterRegistrationIdentifier, 6);
         push(imIn.clusterCycleCounter, 2);
         push(imIn.syncReferenceDomainIdentifier, 3);
         push(imIn.ownDomainIdentifier, 3);
         push(imIn.senderMacAddress, 6);
         push(imIn.presenceHandshakeCode, 1);
         push(imIn.authorizedSenderCount, 1);
         imQ.push_back(imIn);
      end
      for (int k = 0; k < n; k++) begin
         push(noise[8*k +: 8], 1);
         entryQ.push_back({power, noise[8*k +: 8]});
      end
      streamQ[streamQ.size() - 1][8] = 1'b1;
      sendInterference = !power;
      sendPower = power;
      @(posedge clock);
      #1;
      sendInterference = 1'b0;
      // Pulse and list write while busy must be ignored
      check(busy, 1'b1);
      sendPower = 1'b1;
      listWrite = 1'b1;
      listAddr = 8'h00;
      listData = ~noise[7:0];
      @(posedge clock);
      #1;
      sendPower = 1'b0;
      listWrite = 1'b0;
      guard = 0;
      while (busy !== 1'b0) begin
         @(posedge clock);
         #1;
         guard++;
         if (guard > 1000) begin
            n_mismatch++;
            finish_test();
         end
      end
   endtask
   // ********
   // Main sequence
   // ********
   initial begin
      rst_b = 1'b0;
      sendInterference = 1'b0;
      sendPower = 1'b0;
      listWrite = 1'b0;
      listAddr = 8'h00;
      listData = 8'h00;
      imIn = '0;
      psIn = '0;
      noise = '0;
      n_mismatch = 0;
      samples_checked = 0;
      void'($urandom(32'hbbb2));
      repeat (10) @(posedge clock);
      #1;
      rst_b = 1'b1;
      for (int f = 0; f < 10; f++) begin
         send_frame(f[0], f < 2 ? 0 : f == 3 ? 255 : 1 + $urandom % 6,
            f / 2 % 4);
      end
      for (int k = 0; k < 2000 && streamQ.size() + imQ.size() + psQ.size()
         + entryQ.size() != 0; k++) begin
         @(posedge clock);
      end
      if (streamQ.size() + imQ.size() + psQ.size() + entryQ.size() != 0) begin
         n_mismatch++;
      end
      repeat (4) @(posedge clock);
      finish_test();
   end
endmodule
